// ### rtl/aux_adc_pkg.sv
// Constants, register map and state types of the auxiliary converter sequencer
package aux_adc_pkg;

  localparam int CLK_MHZ = 125;
  localparam int NUM_CH = 16;
  localparam int CH_W = 4;
  localparam int RES_BITS = 8;
  localparam int SENSOR_W = 2;
  localparam int SEL_W = CH_W + 1;
  localparam int DEB_W = 4;
  localparam int PER_W = 16;
  localparam int IRQ_W = 3;

  // Analog settling time after power is applied, and its cycle count
  localparam int POWERUP_NS = 1000;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PWR_CNT_W = $clog2(POWERUP_CYC + 1);

  // Register byte offsets
  localparam logic [7:0] ADR_TRIG = 8'h00;
  localparam logic [7:0] ADR_AUTO = 8'h04;
  localparam logic [7:0] ADR_PWR = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;
  localparam logic [7:0] ADR_IRQ_ST = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADR_MON_CFG = 8'h18;
  localparam logic [7:0] ADR_MON_THR = 8'h1c;
  localparam logic [7:0] ADR_MON_PER = 8'h20;
  localparam logic [7:0] ADR_MON_DEB = 8'h24;
  localparam logic [7:0] ADR_THERM = 8'h28;
  localparam logic [7:0] ADR_RES_BASE = 8'h40;
  localparam logic [7:0] ADR_RES_END = 8'h7c;

  // Field positions
  localparam int PWR_WAIT_BIT = 0;
  localparam int MON_EN_BIT = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_MON_BIT = 1;
  localparam int IRQ_THERM_BIT = 2;
  localparam int STAT_CH_LSB = 4;
  localparam int STAT_PEND_LSB = 16;

  // Reset values
  localparam logic [RES_BITS-1:0] THR_RST = 8'h80;
  localparam logic [PER_W-1:0] PER_RST = 16'h0100;
  localparam logic [DEB_W-1:0] DEB_RST = 4'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_POWER = 3'b001,
    ST_CONVERT = 3'b010,
    ST_WAIT = 3'b011,
    ST_STORE = 3'b100
  } seq_state_t;

  typedef enum logic [1:0] {
    SRC_SW = 2'b00,
    SRC_THERM = 2'b01,
    SRC_MON = 2'b10
  } src_t;

endpackage

// ### rtl/aux_adc_sar.sv
// Successive approximation engine, one bit decided per clock
`timescale 1ns/1ns
module aux_adc_sar
  import aux_adc_pkg::*;
#(
  parameter int BITS = RES_BITS
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic comp_in,
  output logic [BITS-1:0] trial,
  output logic busy,
  output logic done,
  output logic [BITS-1:0] result
);

  localparam logic [BITS-1:0] MID = {1'b1, {(BITS-1){1'b0}}};
  localparam int IDX_W = $clog2(BITS);
  localparam logic [IDX_W-1:0] TOP = IDX_W'(BITS - 1);

  logic [IDX_W-1:0] bit_idx;
  logic [IDX_W-1:0] next_bit_idx;
  logic [BITS-1:0] next_trial;
  logic [BITS-1:0] next_result;
  logic next_busy;
  logic next_done;

  always_comb
  begin
    logic [BITS-1:0] t;
    t = trial;
    next_trial = trial;
    next_bit_idx = bit_idx;
    next_busy = busy;
    next_done = 1'b0;
    next_result = result;
    if (start)
    begin
      next_busy = 1'b1;
      next_bit_idx = TOP;
      next_trial = MID;
    end
    else if (busy)
    begin
      t[bit_idx] = comp_in;
      if (bit_idx == '0)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_result = t;
      end
      else
      begin
        next_bit_idx = bit_idx - IDX_W'(1);
        t[bit_idx - IDX_W'(1)] = 1'b1;
      end
      next_trial = t;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      trial <= '0;
      bit_idx <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end
    else
    begin
      trial <= next_trial;
      bit_idx <= next_bit_idx;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
    end
  end

  sar_first_trial_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    start |=> trial == MID)
    else $error("first trial is not mid scale");

  sar_bit_decide_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (busy && !start && bit_idx == TOP) |=> trial[BITS-1] == $past(comp_in))
    else $error("top bit does not follow comparator");

  sar_step_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    start |-> ##9 done)
    else $error("conversion did not finish after one step per bit");

endmodule

// ### rtl/aux_adc_sequencer.sv
// Auxiliary converter sequencer with classic Wishbone register slave
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module aux_adc_sequencer
  import aux_adc_pkg::*;
#(
  parameter int PWR_CYC = POWERUP_CYC
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic comp_in,
  input wire logic therm_req,
  input wire logic [SENSOR_W-1:0] therm_sensor,
  output logic ana_power,
  output logic [SEL_W-1:0] ana_sel,
  output logic [RES_BITS-1:0] ana_trial,
  output logic therm_valid,
  output logic [RES_BITS-1:0] therm_result,
  output logic irq
);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
      byte_mask[8*b +: 8] = {8{sel[b]}};
  endfunction

  function automatic logic [CH_W-1:0] top_index(input logic [NUM_CH-1:0] v);
    top_index = '0;
    for (int i = 0; i < NUM_CH; i++)
      if (v[i])
        top_index = CH_W'(i);
  endfunction

  function automatic logic result_hit(input logic [7:0] adr);
    result_hit = (adr >= ADR_RES_BASE) && (adr <= ADR_RES_END) && (adr[1:0] == 2'b00);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  seq_state_t state, next_state;
  src_t src, next_src;
  logic [CH_W-1:0] cur_ch, next_cur_ch;
  localparam int CNT_W = $clog2(PWR_CYC + 1);
  logic [CNT_W-1:0] pwr_cnt, next_pwr_cnt;
  logic [NUM_CH-1:0] trig, next_trig;
  logic [NUM_CH-1:0] pending, next_pending;
  logic [NUM_CH-1:0] auto_en, next_auto_en;
  logic pwr_wait, next_pwr_wait;
  logic [IRQ_W-1:0] irq_st, next_irq_st;
  logic [IRQ_W-1:0] irq_mask, next_irq_mask;
  logic [CH_W-1:0] mon_ch, next_mon_ch;
  logic mon_en, next_mon_en;
  logic [RES_BITS-1:0] mon_thr, next_mon_thr;
  logic [PER_W-1:0] mon_per, next_mon_per;
  logic [PER_W-1:0] mon_cnt, next_mon_cnt;
  logic [DEB_W-1:0] deb_lim, next_deb_lim;
  logic [DEB_W-1:0] deb_cnt, next_deb_cnt;
  logic mon_over, next_mon_over;
  logic mon_pend, next_mon_pend;
  logic therm_pend, next_therm_pend;
  logic [SENSOR_W-1:0] therm_id, next_therm_id;
  logic [RES_BITS-1:0] result [NUM_CH];
  logic [RES_BITS-1:0] next_result [NUM_CH];
  logic next_ana_power, next_therm_valid, next_irq, next_ack;
  logic [SEL_W-1:0] next_ana_sel;
  logic [RES_BITS-1:0] next_therm_result;
  logic [31:0] next_dat, rd_mux, wmask;
  logic req, wr, rd, sar_start, sar_done, sar_busy;
  logic [RES_BITS-1:0] sar_result;
  logic [NUM_CH-1:0] trig_rise, auto_set, pick_mask;
  logic [CH_W-1:0] hi_ch, rd_idx;
  logic [IRQ_W-1:0] irq_ev;

  aux_adc_sar #(.BITS(RES_BITS)) sar (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(sar_start),
    .comp_in(comp_in),
    .trial(ana_trial),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result)
  );

  // ------------------------------------------------------------
  // Register slave and request bookkeeping
  // ------------------------------------------------------------
  always_comb
  begin
    req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr = req & wb_we_i;
    rd = req & ~wb_we_i;
    wmask = byte_mask(wb_sel_i);
    hi_ch = top_index(pending);
    rd_idx = wb_adr_i[CH_W+1:2];
    case (wb_adr_i)
      ADR_TRIG: rd_mux = 32'(trig);
      ADR_AUTO: rd_mux = 32'(auto_en);
      ADR_PWR: rd_mux = 32'(pwr_wait);
      ADR_STAT: rd_mux = {pending, 8'h00, cur_ch, 3'b000, state != ST_IDLE};
      ADR_IRQ_ST: rd_mux = 32'(irq_st);
      ADR_IRQ_MASK: rd_mux = 32'(irq_mask);
      ADR_MON_CFG: rd_mux = 32'({mon_en, mon_ch});
      ADR_MON_THR: rd_mux = 32'(mon_thr);
      ADR_MON_PER: rd_mux = 32'(mon_per);
      ADR_MON_DEB: rd_mux = 32'(deb_lim);
      ADR_THERM: rd_mux = 32'(therm_result);
      default: rd_mux = result_hit(wb_adr_i) ? 32'(result[rd_idx]) : 32'h0000_0000;
    endcase
    next_ack = req;
    next_dat = rd ? rd_mux : 32'h0000_0000;
    next_trig = trig;
    next_auto_en = auto_en;
    next_pwr_wait = pwr_wait;
    next_irq_mask = irq_mask;
    next_mon_ch = mon_ch;
    next_mon_en = mon_en;
    next_mon_thr = mon_thr;
    next_mon_per = mon_per;
    next_deb_lim = deb_lim;
    trig_rise = '0;
    auto_set = '0;
    if (wr)
    begin
      case (wb_adr_i)
        ADR_TRIG:
        begin
          next_trig = (trig & ~wmask[NUM_CH-1:0]) | (wb_dat_i[NUM_CH-1:0] & wmask[NUM_CH-1:0]);
          trig_rise = next_trig & ~trig;
        end
        ADR_AUTO: next_auto_en = (auto_en & ~wmask[NUM_CH-1:0]) | (wb_dat_i[NUM_CH-1:0] & wmask[NUM_CH-1:0]);
        ADR_PWR: if (wb_sel_i[0]) next_pwr_wait = wb_dat_i[PWR_WAIT_BIT];
        ADR_IRQ_MASK: if (wb_sel_i[0]) next_irq_mask = wb_dat_i[IRQ_W-1:0];
        ADR_MON_CFG:
          if (wb_sel_i[0])
          begin
            next_mon_ch = wb_dat_i[CH_W-1:0];
            next_mon_en = wb_dat_i[MON_EN_BIT];
          end
        ADR_MON_THR: if (wb_sel_i[0]) next_mon_thr = wb_dat_i[RES_BITS-1:0];
        ADR_MON_PER: next_mon_per = (mon_per & ~wmask[PER_W-1:0]) | (wb_dat_i[PER_W-1:0] & wmask[PER_W-1:0]);
        ADR_MON_DEB: if (wb_sel_i[0]) next_deb_lim = wb_dat_i[DEB_W-1:0];
        default: next_trig = trig;
      endcase
    end
    if (rd && result_hit(wb_adr_i) && auto_en[rd_idx])
      auto_set[rd_idx] = 1'b1;
  end

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_src = src;
    next_cur_ch = cur_ch;
    next_pwr_cnt = pwr_cnt;
    next_ana_power = ana_power;
    next_ana_sel = ana_sel;
    next_result = result;
    next_therm_result = therm_result;
    next_therm_valid = 1'b0;
    sar_start = 1'b0;
    pick_mask = '0;
    irq_ev = '0;
    next_therm_pend = therm_pend | therm_req;
    next_therm_id = therm_req ? therm_sensor : therm_id;
    next_mon_pend = mon_pend;
    next_mon_cnt = mon_cnt;
    next_deb_cnt = deb_cnt;
    next_mon_over = mon_over;
    if (mon_en)
    begin
      if (mon_cnt >= mon_per)
      begin
        next_mon_cnt = '0;
        next_mon_pend = 1'b1;
      end
      else
        next_mon_cnt = mon_cnt + PER_W'(1);
    end
    unique case (state)
      ST_IDLE:
        if (|pending || therm_pend || mon_pend)
        begin
          if (|pending)
          begin
            next_src = SRC_SW;
            next_cur_ch = hi_ch;
            next_ana_sel = {1'b0, hi_ch};
            pick_mask[hi_ch] = 1'b1;
          end
          else if (therm_pend)
          begin
            next_src = SRC_THERM;
            next_therm_pend = therm_req;
            next_ana_sel = {1'b1, {(CH_W-SENSOR_W){1'b0}}, therm_id};
          end
          else
          begin
            next_src = SRC_MON;
            next_mon_pend = mon_en && (mon_cnt >= mon_per); // A period ending now is not lost
            next_ana_sel = {1'b0, mon_ch};
          end
          next_ana_power = 1'b1;
          next_pwr_cnt = CNT_W'(PWR_CYC - 1);
          next_state = pwr_wait ? ST_POWER : ST_CONVERT;
        end
      ST_POWER:
        if (pwr_cnt == '0)
          next_state = ST_CONVERT;
        else
          next_pwr_cnt = pwr_cnt - CNT_W'(1);
      ST_CONVERT:
      begin
        sar_start = 1'b1;
        next_state = ST_WAIT;
      end
      ST_WAIT:
        if (sar_done)
          next_state = ST_STORE;
      ST_STORE:
      begin
        next_ana_power = 1'b0;
        next_state = ST_IDLE;
        unique case (src)
          SRC_SW:
          begin
            next_result[cur_ch] = sar_result;
            irq_ev[IRQ_DONE_BIT] = 1'b1;
          end
          SRC_THERM:
          begin
            next_therm_result = sar_result;
            next_therm_valid = 1'b1;
            irq_ev[IRQ_THERM_BIT] = 1'b1;
          end
          default:
          begin
            if (sar_result > mon_thr)
            begin
              next_deb_cnt = (deb_cnt == deb_lim) ? deb_cnt : deb_cnt + DEB_W'(1);
              next_mon_over = (next_deb_cnt == deb_lim);
            end
            else
            begin
              next_deb_cnt = '0;
              next_mon_over = 1'b0;
            end
            irq_ev[IRQ_MON_BIT] = next_mon_over & ~mon_over;
          end
        endcase
      end
    endcase
    next_pending = (pending & ~pick_mask) | trig_rise | auto_set;
    next_irq_st = (irq_st & ~((wr && wb_adr_i == ADR_IRQ_ST) ? wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0] : '0))
                  | irq_ev;
    next_irq = |(next_irq_st & next_irq_mask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      src <= SRC_SW;
      cur_ch <= '0;
      pwr_cnt <= '0;
      trig <= '0;
      pending <= '0;
      auto_en <= '0;
      pwr_wait <= 1'b0;
      irq_st <= '0;
      irq_mask <= '0;
      mon_ch <= '0;
      mon_en <= 1'b0;
      mon_thr <= THR_RST;
      mon_per <= PER_RST;
      mon_cnt <= '0;
      deb_lim <= DEB_RST;
      deb_cnt <= '0;
      mon_over <= 1'b0;
      mon_pend <= 1'b0;
      therm_pend <= 1'b0;
      therm_id <= '0;
      for (int i = 0; i < NUM_CH; i++)
        result[i] <= '0;
      ana_power <= 1'b0;
      ana_sel <= '0;
      therm_valid <= 1'b0;
      therm_result <= '0;
      irq <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      state <= next_state;
      src <= next_src;
      cur_ch <= next_cur_ch;
      pwr_cnt <= next_pwr_cnt;
      trig <= next_trig;
      pending <= next_pending;
      auto_en <= next_auto_en;
      pwr_wait <= next_pwr_wait;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      mon_ch <= next_mon_ch;
      mon_en <= next_mon_en;
      mon_thr <= next_mon_thr;
      mon_per <= next_mon_per;
      mon_cnt <= next_mon_cnt;
      deb_lim <= next_deb_lim;
      deb_cnt <= next_deb_cnt;
      mon_over <= next_mon_over;
      mon_pend <= next_mon_pend;
      therm_pend <= next_therm_pend;
      therm_id <= next_therm_id;
      result <= next_result;
      ana_power <= next_ana_power;
      ana_sel <= next_ana_sel;
      therm_valid <= next_therm_valid;
      therm_result <= next_therm_result;
      irq <= next_irq;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  localparam int PWR_CYC_A = PWR_CYC;

  sequence enter_power;
    state == ST_IDLE ##1 state == ST_POWER;
  endsequence

  sequence conversion_begins;
    state == ST_CONVERT && ana_power;
  endsequence

  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  trigger_pending_a: assert property (
    (wr && wb_adr_i == ADR_TRIG && wb_sel_i[0] && wb_dat_i[0] && !trig[0]) |=> pending[0])
    else $error("raised flag did not queue its channel");

  auto_resample_a: assert property (
    (rd && result_hit(wb_adr_i) && auto_en[rd_idx]) |=> pending[$past(rd_idx)])
    else $error("result read did not requeue channel");

  high_first_a: assert property (
    (state == ST_IDLE && |pending) |=> (cur_ch == $past(hi_ch) && src == SRC_SW))
    else $error("lower channel picked before higher one");

  powerup_wait_a: assert property (enter_power |-> ##PWR_CYC_A conversion_begins)
    else $error("conversion did not follow the power-up wait");

  power_down_a: assert property ((state == ST_STORE) |=> !ana_power)
    else $error("analog power left on after conversion");

  result_store_a: assert property (
    (state == ST_STORE && src == SRC_SW) |=> result[$past(cur_ch)] == $past(sar_result))
    else $error("result not written to its channel register");

  thermal_served_a: assert property (
    (state == ST_IDLE && !(|pending) && therm_pend) |=> ana_sel[SEL_W-1] && src == SRC_THERM)
    else $error("thermal request not routed to sensor");

  irq_level_a: assert property (irq == |(irq_st & irq_mask))
    else $error("interrupt output disagrees with status and mask");

endmodule

// ### verification/aux_adc_analog_model.sv
// Behavioural analog converter core with its channel and sensor inputs
`timescale 1ns/1ns
module aux_adc_analog_model
  import aux_adc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic ana_power,
  input wire logic [SEL_W-1:0] ana_sel,
  input wire logic [RES_BITS-1:0] ana_trial,
  input wire logic [7:0] offset,
  output logic comp_in
);
  logic [7:0] vin;
  logic toggle = 1'b0;
  // An unpowered comparator says nothing useful, so its output wanders
  always @(posedge clk_sys)
    toggle <= ~toggle;
  assign vin = ana_sel[4] ? 8'ha0 + {3'h0, ana_sel[1:0], 3'h0} : {ana_sel[3:0], 4'h5} + offset;
  assign comp_in = ana_power ? (vin > ana_trial) : toggle;
endmodule

// ### verification/aux_adc_sequencer_tb_top.sv
// Register level testbench of the auxiliary converter sequencer
`timescale 1ns/1ns
module aux_adc_sequencer_tb_top;
  import aux_adc_pkg::*;
  localparam int PCYC = 4;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic comp_in;
  logic therm_req = 1'b0;
  logic [SENSOR_W-1:0] therm_sensor = 2'h0;
  logic ana_power;
  logic [SEL_W-1:0] ana_sel;
  logic [RES_BITS-1:0] ana_trial;
  logic therm_valid;
  logic [RES_BITS-1:0] therm_result;
  logic irq;
  logic [7:0] offset = 8'h00;
  int mismatches = 0;
  int num_checks = 0;
  logic [SEL_W-1:0] sel_log[$];
  int gap_cnt = 0;
  logic gap_run = 1'b0;
  logic pwr_q = 1'b0;
  logic [31:0] rd;
  int n;

  initial
    forever #4 clk_sys = ~clk_sys;

  aux_adc_sequencer #(.PWR_CYC(PCYC)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_in(comp_in), .therm_req(therm_req),
    .therm_sensor(therm_sensor), .ana_power(ana_power), .ana_sel(ana_sel), .ana_trial(ana_trial),
    .therm_valid(therm_valid), .therm_result(therm_result), .irq(irq));

  aux_adc_analog_model model (.clk_sys(clk_sys), .ana_power(ana_power), .ana_sel(ana_sel),
    .ana_trial(ana_trial), .offset(offset), .comp_in(comp_in));

  // ----------------------------------------------------------------
  // Conversion log: select at each power-up, cycles until first trial
  // ----------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (ana_power && !pwr_q)
    begin
      sel_log.push_back(ana_sel);
      gap_cnt = 0;
      gap_run = 1'b1;
    end
    else if (gap_run)
    begin
      gap_cnt++;
      if (ana_trial === 8'h80)
        gap_run = 1'b0;
    end
    pwr_q = ana_power;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (wb_ack_o !== 1'b1);
    check(k, 2);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      wb(1'b0, ADR_STAT, 32'h0);
      k++;
    end
    while ((rd[0] !== 1'b0 || rd[31:16] !== 16'h0) && k < 300);
    check(rd, {16'h0, rd[15:1], 1'b0});
  endtask

  function automatic logic [7:0] expect_ch(input int ch);
    logic [7:0] v;
    v = 8'(ch * 16 + 5) + offset;
    return v - 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wb(1'b0, ADR_MON_THR, 32'h0);
    check(rd, 32'h80);
    wb(1'b0, ADR_MON_PER, 32'h0);
    check(rd, 32'h100);
    wb(1'b0, ADR_MON_DEB, 32'h0);
    check(rd, 32'h2);
    wb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    // All sixteen channels at once, highest first
    wb(1'b1, ADR_TRIG, 32'hffff);
    wait_idle();
    check(sel_log.size(), 16);
    for (n = 0; n < 16; n++)
    begin
      check(sel_log[n], 5'(15 - n));
      wb(1'b0, ADR_RES_BASE + 8'(4 * n), 32'h0);
      check(rd, {24'h0, expect_ch(n)});
    end
    check(gap_cnt, 1);
    check(ana_power, 1'b0);
    // Rewriting a set flag must not convert again
    wb(1'b1, ADR_TRIG, 32'hffff);
    repeat (300) @(posedge clk_sys);
    check(sel_log.size(), 16);
    // Sticky done status, mask and write-one-to-clear
    wb(1'b0, ADR_IRQ_ST, 32'h0);
    check(rd[0], 1'b1);
    check(irq, 1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b1);
    wb(1'b1, ADR_IRQ_ST, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b0);
    // Auto-resample on result read
    wb(1'b1, ADR_TRIG, 32'h0);
    wb(1'b1, ADR_AUTO, 32'h4);
    offset <= 8'h03;
    wb(1'b0, ADR_RES_BASE + 8'h08, 32'h0);
    check(rd, 32'h24);
    wait_idle();
    check(sel_log.size(), 17);
    check(sel_log[16], 5'h02);
    wb(1'b0, ADR_RES_BASE + 8'h08, 32'h0);
    check(rd, {24'h0, expect_ch(2)});
    wb(1'b1, ADR_AUTO, 32'h0);
    wait_idle();
    wb(1'b0, ADR_RES_BASE + 8'h0c, 32'h0);
    repeat (30) @(posedge clk_sys);
    check(sel_log.size(), 18);
    // Power-up wait before conversion
    wb(1'b1, ADR_PWR, 32'h1);
    wb(1'b1, ADR_TRIG, 32'h10);
    wait_idle();
    check(gap_cnt, PCYC + 1);
    check(ana_power, 1'b0);
    wb(1'b0, ADR_RES_BASE + 8'h10, 32'h0);
    check(rd, {24'h0, expect_ch(4)});
    wb(1'b1, ADR_PWR, 32'h0);
    // Thermal controller measurement of sensor 2
    @(posedge clk_sys);
    therm_req <= 1'b1;
    therm_sensor <= 2'h2;
    @(posedge clk_sys);
    therm_req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (therm_valid !== 1'b1 && n < 300);
    check(therm_valid, 1'b1);
    repeat (2) @(posedge clk_sys);
    check(therm_result, 8'haf);
    check(sel_log[sel_log.size() - 1], 5'h12);
    wb(1'b0, ADR_THERM, 32'h0);
    check(rd, 32'haf);
    // Background monitor crossing interrupt
    wb(1'b1, ADR_IRQ_MASK, 32'h2);
    wb(1'b1, ADR_MON_THR, 32'h20);
    wb(1'b1, ADR_MON_PER, 32'h10);
    wb(1'b1, ADR_MON_CFG, 32'h15);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (irq !== 1'b1 && n < 2000);
    check(irq, 1'b1);
    wb(1'b1, ADR_MON_CFG, 32'h0);
    wait_idle();
    wb(1'b1, ADR_IRQ_ST, 32'h2);
    repeat (2) @(posedge clk_sys);
    check(irq, 1'b0);
    give_verdict();
  end

  initial
  begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule
